// ### design/nv_cfg_pkg.sv
// shared constants for the non-volatile configuration store and its host
package nv_cfg_pkg;
    localparam logic [6:0] ADDR_STATUS      = 7'h70;
    localparam logic [6:0] ADDR_STARTUP     = 7'h73;
    localparam logic [6:0] ADDR_CHIPCFG     = 7'h74;
    localparam logic [6:0] ADDR_CRC         = 7'h75;
    localparam logic [7:0] CRC_POLY         = 8'h2f;
    localparam logic [7:0] CRC_INIT         = 8'hff;
    localparam logic [7:0] CRC_XOR          = 8'hff;
    localparam logic [7:0] PRESET_STARTUP   = 8'h00;
    localparam logic [7:0] PRESET_CHIPCFG   = 8'h00;
    localparam int         READY_BIT        = 0;
    localparam int         ERROR_BIT        = 1;
    localparam int         CNT_LSB          = 2;
    localparam logic [5:0] CNT_MAX          = 6'h3f;
    localparam logic [5:0] CNT_RESET        = 6'h00;
    // cycles one cell programming cycle lasts
    localparam logic [7:0] PROG_CYCLES      = 8'h10;
    // one more than the cycles the restore pin condition must hold
    localparam logic [7:0] RESTORE_CYCLES   = 8'h08;
    // cycles the system reset pulse lasts
    localparam logic [3:0] SYSRST_CYCLES    = 4'h4;
    // host register map (ahb byte addresses)
    localparam logic [7:0] HREG_CTRL        = 8'h00;
    localparam logic [7:0] HREG_DATA        = 8'h04;
    localparam logic [7:0] HREG_STAT        = 8'h08;
    localparam logic [7:0] HREG_RDATA       = 8'h0c;
    localparam int         CTRL_GO          = 0;
    localparam int         CTRL_WRITE       = 1;
    localparam int         CTRL_ADDR_LSB    = 8;
    localparam int         STAT_BUSY        = 0;
    localparam int         STAT_DONE        = 1;

    function automatic logic [7:0] crc_byte(input logic [7:0] crc,
                                            input logic [7:0] dat);
        logic [7:0] d;
        d = crc ^ dat;
        for (int j = 0; j < 8; j++) begin
            d = d[7] ? ((d << 1) ^ CRC_POLY) : (d << 1);
        end
        return d;
    endfunction

    function automatic logic [7:0] crc_pair(input logic [7:0] b0,
                                            input logic [7:0] b1);
        return crc_byte(crc_byte(CRC_INIT, b0), b1) ^ CRC_XOR;
    endfunction
endpackage

// ### design/nv_reg_if.sv
// register access link between host and configuration store
`timescale 1ns/100ps
interface nv_reg_if;
    logic       req;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    modport dev  (input req, wr, addr, wdata, output ack, rdata);
    modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface

// ### design/nv_config_store.sv
// non-volatile configuration store with crc-confirmed programming
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module nv_config_store
    import nv_cfg_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic reset_i,
    nv_reg_if.dev     bus,
    input  wire logic power_up_i,
    input  wire logic reset_pin_n_i,
    input  wire logic canh_high_i,
    input  wire logic canl_low_i,
    input  wire logic cell_fault_i,
    output logic      forced_normal_o,
    output logic      system_reset_o,
    output logic [7:0] startup_cfg_o,
    output logic [7:0] chip_cfg_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_DONE} state_e;

    state_e     state_ff;
    logic [7:0] cell_su_ff, cell_cc_ff;
    logic [7:0] shadow_su_ff, shadow_cc_ff;
    logic [7:0] crc_confirm_value_ff;
    logic       reprogram_ready_flag_ff;
    logic       program_error_flag_ff;
    logic [5:0] program_cycle_counter_ff;
    logic [7:0] prog_cnt_ff;
    logic [7:0] restore_cnt_ff;
    logic [3:0] sysrst_cnt_ff;
    logic       ack_ff;
    logic [7:0] rdata_ff;
    logic [1:0] rp_sync_ff, ch_sync_ff, cl_sync_ff, pu_sync_ff;
    logic       restore_pulse;
    logic       wr_hit, crc_ok, start_prog, forced_normal_control;

    // counter sticks at all ones instead of wrapping
    function automatic logic [5:0] sat_inc(input logic [5:0] c);
        return (c == CNT_MAX) ? c : c + 6'h01;
    endfunction

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rp_sync_ff <= 2'h3;
            ch_sync_ff <= 2'h0;
            cl_sync_ff <= 2'h0;
            pu_sync_ff <= 2'h0;
        end else begin
            rp_sync_ff <= {rp_sync_ff[0], reset_pin_n_i};
            ch_sync_ff <= {ch_sync_ff[0], canh_high_i};
            cl_sync_ff <= {cl_sync_ff[0], canl_low_i};
            pu_sync_ff <= {pu_sync_ff[0], power_up_i};
        end
    end

    // restore condition must persist for the qualifying time
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            restore_cnt_ff <= 8'h00;
        end else if (pu_sync_ff[1] && !rp_sync_ff[1] && ch_sync_ff[1]
                     && cl_sync_ff[1]) begin
            if (restore_cnt_ff != RESTORE_CYCLES)
                restore_cnt_ff <= restore_cnt_ff + 8'h01;
        end else begin
            restore_cnt_ff <= 8'h00;
        end
    end
    assign restore_pulse = (restore_cnt_ff == RESTORE_CYCLES - 8'h01);

    // factory presets hold forced normal control at one
    assign forced_normal_control = reprogram_ready_flag_ff;

    assign wr_hit = bus.req && bus.wr && !ack_ff;
    assign crc_ok = (bus.wdata == crc_pair(shadow_su_ff, shadow_cc_ff));
    assign start_prog = wr_hit && bus.addr == ADDR_CRC && state_ff == ST_IDLE
                        && forced_normal_control
                        && reprogram_ready_flag_ff && crc_ok;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus.req && !ack_ff;
        end
    end

    // configuration bytes land in shadows, committed only by programming
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            shadow_su_ff <= PRESET_STARTUP;
            shadow_cc_ff <= PRESET_CHIPCFG;
            crc_confirm_value_ff <= 8'h00;
        end else if (restore_pulse) begin
            shadow_su_ff <= PRESET_STARTUP;
            shadow_cc_ff <= PRESET_CHIPCFG;
        end else if (wr_hit && reprogram_ready_flag_ff
                     && state_ff == ST_IDLE) begin
            if (bus.addr == ADDR_STARTUP)
                shadow_su_ff <= bus.wdata;
            if (bus.addr == ADDR_CHIPCFG)
                shadow_cc_ff <= bus.wdata;
            if (bus.addr == ADDR_CRC)
                crc_confirm_value_ff <= bus.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            prog_cnt_ff <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    prog_cnt_ff <= 8'h00;
                    if (start_prog)
                        state_ff <= ST_PROG;
                end
                ST_PROG: begin
                    prog_cnt_ff <= prog_cnt_ff + 8'h01;
                    if (prog_cnt_ff == PROG_CYCLES - 8'h01)
                        state_ff <= ST_DONE;
                end
                ST_DONE: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // cell array and status survive the system reset they cause
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cell_su_ff <= PRESET_STARTUP;
            cell_cc_ff <= PRESET_CHIPCFG;
            reprogram_ready_flag_ff <= 1'b1;
            program_error_flag_ff <= 1'b0;
            program_cycle_counter_ff <= CNT_RESET;
        end else if (restore_pulse) begin
            cell_su_ff <= PRESET_STARTUP;
            cell_cc_ff <= PRESET_CHIPCFG;
            reprogram_ready_flag_ff <= 1'b1;
            // an error reported in the same cycle is not lost
            program_error_flag_ff <= (state_ff == ST_DONE)
                                     && cell_fault_i;
            program_cycle_counter_ff <= sat_inc(program_cycle_counter_ff);
        end else if (state_ff == ST_DONE) begin
            if (!cell_fault_i) begin
                cell_su_ff <= shadow_su_ff;
                cell_cc_ff <= shadow_cc_ff;
            end
            program_error_flag_ff <= cell_fault_i;
            reprogram_ready_flag_ff <= 1'b0;
            program_cycle_counter_ff <= sat_inc(program_cycle_counter_ff);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sysrst_cnt_ff <= 4'h0;
            system_reset_o <= 1'b0;
        end else if (restore_pulse || state_ff == ST_DONE) begin
            sysrst_cnt_ff <= SYSRST_CYCLES;
            system_reset_o <= 1'b1;
        end else if (sysrst_cnt_ff != 4'h0) begin
            sysrst_cnt_ff <= sysrst_cnt_ff - 4'h1;
            system_reset_o <= (sysrst_cnt_ff != 4'h1);
        end else begin
            system_reset_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            forced_normal_o <= 1'b1;
            startup_cfg_o <= PRESET_STARTUP;
            chip_cfg_o <= PRESET_CHIPCFG;
        end else begin
            forced_normal_o <= forced_normal_control;
            startup_cfg_o <= cell_su_ff;
            chip_cfg_o <= cell_cc_ff;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_ff <= 8'h00;
        end else if (bus.req && !ack_ff) begin
            case (bus.addr)
                ADDR_STATUS:  rdata_ff <= {program_cycle_counter_ff,
                                           program_error_flag_ff,
                                           reprogram_ready_flag_ff};
                ADDR_STARTUP: rdata_ff <= (state_ff == ST_PROG) ? 8'h00
                                         : (reprogram_ready_flag_ff
                                            ? shadow_su_ff : cell_su_ff);
                ADDR_CHIPCFG: rdata_ff <= (state_ff == ST_PROG) ? 8'h00
                                         : (reprogram_ready_flag_ff
                                            ? shadow_cc_ff : cell_cc_ff);
                ADDR_CRC:     rdata_ff <= crc_confirm_value_ff;
                default:      rdata_ff <= 8'h00;
            endcase
        end
    end

    assign bus.ack = ack_ff;
    assign bus.rdata = rdata_ff;
endmodule

// ### design/nv_config_host.sv
// host end: ahb-lite slave that issues single register accesses
`timescale 1ns/100ps
module nv_config_host
    import nv_cfg_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    nv_reg_if.host           bus
);
    logic       ph_wr_ff;
    logic [7:0] ph_addr_ff;
    logic       busy_ff, done_ff;
    logic       req_ff, wr_ff;
    logic [6:0] addr_ff;
    logic [7:0] wdata_ff, rd_ff, data_ff;
    logic       go;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ph_wr_ff <= 1'b0;
            ph_addr_ff <= 8'h00;
        end else if (hready_i) begin
            ph_wr_ff <= hsel_i && htrans_i[1] && hwrite_i;
            ph_addr_ff <= haddr_i[7:0];
        end
    end

    assign go = ph_wr_ff && ph_addr_ff == HREG_CTRL && hwdata_i[CTRL_GO]
                && !busy_ff;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            data_ff <= 8'h00;
        end else if (ph_wr_ff && ph_addr_ff == HREG_DATA) begin
            data_ff <= hwdata_i[7:0];
        end
    end

    // one register access on the link per go write
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            req_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 7'h00;
            wdata_ff <= 8'h00;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            rd_ff <= 8'h00;
        end else if (go) begin
            req_ff <= 1'b1;
            wr_ff <= hwdata_i[CTRL_WRITE];
            addr_ff <= hwdata_i[CTRL_ADDR_LSB +: 7];
            wdata_ff <= data_ff;
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (req_ff && bus.ack) begin
            req_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            rd_ff <= bus.rdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0;
        end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            case (haddr_i[7:0])
                HREG_CTRL:  hrdata_o <= {16'h0, 1'b0, addr_ff, 6'h0,
                                         wr_ff, 1'b0};
                HREG_DATA:  hrdata_o <= {24'h0, data_ff};
                HREG_STAT:  hrdata_o <= {30'h0, done_ff, busy_ff};
                HREG_RDATA: hrdata_o <= {24'h0, rd_ff};
                default:    hrdata_o <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    assign bus.req = req_ff;
    assign bus.wr = wr_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = wdata_ff;
endmodule

// ### tb/nv_link_properties.sv
// checker for the register link between host end and store
`timescale 1ns/100ps
module nv_link_properties
    import nv_cfg_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       req,
    input  wire logic       wr,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       ack,
    input  wire logic [7:0] rdata
);
    logic       stat_rd;
    logic [7:0] last_ff;
    logic       seen_ff;

    assign stat_rd = ack && !wr && addr == ADDR_STATUS;

    // last status byte seen on the link, to relate successive reads
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            last_ff <= 8'h01;
            seen_ff <= 1'b0;
        end else if (stat_rd) begin
            last_ff <= rdata;
            seen_ff <= 1'b1;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_ack_after_req; $rose(req) |=> ack; endproperty
    a_ack_after_req: assert property (p_ack_after_req)
        else $error("ack missing one cycle after request");
    property p_ack_single; ack |=> !ack; endproperty
    a_ack_single: assert property (p_ack_single)
        else $error("ack longer than one cycle");
    property p_ack_with_req; ack |-> req; endproperty
    a_ack_with_req: assert property (p_ack_with_req)
        else $error("ack without request");
    property p_req_hold;
        req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request changed before ack");
    property p_req_release; ack |=> !req; endproperty
    a_req_release: assert property (p_req_release)
        else $error("request not dropped after ack");
    property p_first_status; stat_rd && !seen_ff |-> rdata == 8'h01; endproperty
    a_first_status: assert property (p_first_status)
        else $error("status after reset not ready");
    property p_cnt_monotone; stat_rd |-> rdata[7:2] >= last_ff[7:2]; endproperty
    a_cnt_monotone: assert property (p_cnt_monotone)
        else $error("cycle counter went down");
    property p_prog_count;
        stat_rd && last_ff[0] && !rdata[0] |-> rdata[7:2] ==
            ((last_ff[7:2] == 6'h3f) ? 6'h3f : last_ff[7:2] + 6'h01);
    endproperty
    a_prog_count: assert property (p_prog_count)
        else $error("counter not bumped by programming");
    property p_restore_count;
        stat_rd && !last_ff[0] && rdata[0] |->
            rdata[7:2] > last_ff[7:2] || last_ff[7:2] == 6'h3f;
    endproperty
    a_restore_count: assert property (p_restore_count)
        else $error("counter not bumped by restore");

    cover property (stat_rd && !rdata[0]);
    cover property (stat_rd && rdata[7:2] == 6'h3f);
    cover property (stat_rd && rdata[1]);
endmodule

// ### tb/tb_nv_config_programming_crc.sv
// self-checking bench: host end and store joined by the register link
`timescale 1ns/100ps
module tb_nv_config_programming_crc
    import nv_cfg_pkg::*;
;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_s;
    localparam row_s ROWS [4] = '{
        '{7'h73, 8'hff, 8'hff}, '{7'h74, 8'h00, 8'h00},
        '{7'h73, 8'ha5, 8'ha5}, '{7'h74, 8'h3c, 8'h3c}};
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        power_up = 1'b0;
    logic        pin_n = 1'b1;
    logic        canh = 1'b0;
    logic        canl = 1'b0;
    logic        fault = 1'b0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        fnm;
    logic        sysrst;
    logic        sr_q = 1'b0;
    logic [7:0]  st_cfg;
    logic [7:0]  ch_cfg;
    logic [7:0]  q;
    logic [7:0]  hi_len = 8'h00;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          n_rst = 0;
    int          cyc = 0;
    int          base;

    nv_reg_if i_nv_reg_if ();
    nv_config_host i_nv_config_host (.mclk_i(mclk_i), .reset_i(reset_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .bus(i_nv_reg_if));
    nv_config_store i_nv_config_store (.mclk_i(mclk_i), .reset_i(reset_i),
        .bus(i_nv_reg_if), .power_up_i(power_up), .reset_pin_n_i(pin_n),
        .canh_high_i(canh), .canl_low_i(canl), .cell_fault_i(fault),
        .forced_normal_o(fnm), .system_reset_o(sysrst),
        .startup_cfg_o(st_cfg), .chip_cfg_o(ch_cfg));
    nv_link_properties i_nv_link_properties (.mclk_i(mclk_i),
        .reset_i(reset_i), .req(i_nv_reg_if.req), .wr(i_nv_reg_if.wr),
        .addr(i_nv_reg_if.addr), .wdata(i_nv_reg_if.wdata),
        .ack(i_nv_reg_if.ack), .rdata(i_nv_reg_if.rdata));

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // reference crc, written independently of the design's helper
    function automatic logic [7:0] crc_calc(input logic [7:0] b0,
                                            input logic [7:0] b1);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 0; i < 2; i++) begin
            c = c ^ ((i == 0) ? b0 : b1);
            for (int j = 0; j < 8; j++)
                c = c[7] ? ({c[6:0], 1'b0} ^ 8'h2f) : {c[6:0], 1'b0};
        end
        return ~c;
    endfunction

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge mclk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk_i); while (hready !== 1'b1);
        rd = hrdata;
        chk({7'h0, hresp}, 8'h00);
    endtask

    task automatic dev(input logic w, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] rd);
        logic [31:0] s;
        ahb(1'b1, HREG_DATA, {24'h0, d}, s);
        ahb(1'b1, HREG_CTRL, {17'h0, a, 6'h0, w, 1'b1}, s);
        do ahb(1'b0, HREG_STAT, 32'h0, s); while (s[STAT_BUSY] !== 1'b0);
        ahb(1'b0, HREG_RDATA, 32'h0, s);
        rd = s[7:0];
    endtask

    task automatic prog(input logic [7:0] b0, input logic [7:0] b1);
        dev(1'b1, ADDR_STARTUP, b0, q);
        dev(1'b1, ADDR_CHIPCFG, b1, q);
        dev(1'b1, ADDR_CRC, crc_calc(b0, b1), q);
        repeat (30) @(posedge mclk_i);
    endtask

    task automatic restore();
        power_up <= 1'b1;
        pin_n <= 1'b0;
        canh <= 1'b1;
        canl <= 1'b1;
        repeat (12) @(posedge mclk_i);
        power_up <= 1'b0;
        pin_n <= 1'b1;
        canh <= 1'b0;
        canl <= 1'b0;
        repeat (12) @(posedge mclk_i);
    endtask

    always @(posedge mclk_i) begin
        cyc++;
        sr_q <= sysrst;
        hi_len <= sysrst ? hi_len + 8'h01 : 8'h00;
        if (sysrst === 1'b1 && sr_q === 1'b0)
            n_rst++;
        if (sysrst === 1'b0 && sr_q === 1'b1)
            chk(hi_len, {4'h0, SYSRST_CYCLES});
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] r;
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        foreach (ROWS[i]) begin
            dev(1'b1, ROWS[i].addr, ROWS[i].wdata, q);
            dev(1'b0, ROWS[i].addr, 8'h00, q);
            chk(q, ROWS[i].exp);
        end
        ahb(1'b0, 8'h40, 32'h0, r);
        chk(r[7:0], 8'h00);
        base = n_rst;
        dev(1'b1, ADDR_CRC, crc_calc(8'ha5, 8'h3c) ^ 8'h01, q);
        repeat (30) @(posedge mclk_i);
        chk(8'(n_rst - base), 8'h00);
        chk(st_cfg, 8'h00);
        dev(1'b0, ADDR_STATUS, 8'h00, q);
        chk(q, 8'h01);
        dev(1'b1, ADDR_CRC, crc_calc(8'ha5, 8'h3c), q);
        dev(1'b0, ADDR_STARTUP, 8'h00, q);
        chk(q, 8'h00);
        repeat (30) @(posedge mclk_i);
        chk(8'(n_rst - base), 8'h01);
        chk(st_cfg, 8'ha5);
        chk(ch_cfg, 8'h3c);
        dev(1'b0, ADDR_STATUS, 8'h00, q);
        chk(q, 8'h04);
        chk({7'h0, fnm}, 8'h00);
        base = n_rst;
        dev(1'b1, ADDR_STARTUP, 8'hff, q);
        ahb(1'b0, HREG_DATA, 32'h0, r);
        chk(r[7:0], 8'hff);
        ahb(1'b0, HREG_CTRL, 32'h0, r);
        chk({1'b0, r[14:8]}, 8'h73);
        chk(r[7:0], 8'h02);
        ahb(1'b0, HREG_STAT, 32'h0, r);
        chk(r[7:0], 8'h02);
        dev(1'b0, ADDR_STARTUP, 8'h00, q);
        chk(q, 8'ha5);
        dev(1'b1, ADDR_CRC, crc_calc(8'ha5, 8'h3c), q);
        repeat (30) @(posedge mclk_i);
        chk(8'(n_rst - base), 8'h00);
        chk(st_cfg, 8'ha5);
        restore();
        chk(8'(n_rst - base), 8'h01);
        chk({7'h0, fnm}, 8'h01);
        chk(st_cfg, PRESET_STARTUP);
        dev(1'b0, ADDR_STATUS, 8'h00, q);
        chk(q, 8'h09);
        fault <= 1'b1;
        prog(8'h11, 8'h22);
        fault <= 1'b0;
        dev(1'b0, ADDR_STATUS, 8'h00, q);
        chk(q, 8'h0e);
        repeat (62) restore();
        dev(1'b0, ADDR_STATUS, 8'h00, q);
        chk(q & 8'hfd, 8'hfd);
        prog(8'ha5, 8'h3c);
        chk(st_cfg, 8'ha5);
        dev(1'b0, ADDR_STATUS, 8'h00, q);
        chk(q, 8'hfc);
        reset_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        chk({7'h0, fnm}, 8'h01);
        chk(st_cfg | ch_cfg, 8'h00);
        dev(1'b0, ADDR_STATUS, 8'h00, q);
        chk(q, 8'h01);
        stop_test();
    end
endmodule
